// >>> logic/lnd_pkg.sv
package lnd_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_INT_EN = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_RESULT = 12'h00C;
  // Control register fields
  localparam int CTRL_E1_MODE     = 0;
  localparam int CTRL_CODING      = 1;
  localparam int CTRL_ZERO_STD    = 2;
  localparam int CTRL_ERRSEL_LSB  = 3;
  localparam int CTRL_REPORT_MODE = 5;
  localparam int CTRL_TRANSFER    = 6;
  localparam int CTRL_LOSS_CRIT   = 7;
  localparam int CTRL_LONG_HAUL   = 8;
  localparam int CTRL_ALL_ONES    = 9;
  localparam int CTRL_EDGE_SEL    = 10;
  localparam int CTRL_THRESH_LSB  = 11;
  localparam int CTRL_WIDTH       = 16;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // Interrupt status / enable bit positions
  localparam int ST_VIOL = 0;
  localparam int ST_ZRUN = 1;
  localparam int ST_OVF  = 2;
  localparam int ST_LOSS = 3;
  localparam int ST_LOSS_STATE = 8;
  localparam logic [3:0] INT_EN_RST = 4'h0;
  localparam logic [1:0] ERR_COUNT_SEL = 2'h1;
  // Excessive-zero limits (run longer than this is an error)
  localparam logic [7:0] ZL_AMI_ANSI = 8'h0F;
  localparam logic [7:0] ZL_AMI_FCC  = 8'h50;
  localparam logic [7:0] ZL_B8ZS     = 8'h07;
  localparam logic [7:0] ZL_HDB3     = 8'h03;
  // Loss-of-signal declare intervals, in bits
  localparam logic [11:0] DECL_T1_ANSI = 12'h0AF;
  localparam logic [11:0] DECL_T1_ITU  = 12'h608;
  localparam logic [11:0] DECL_E1_G775 = 12'h020;
  localparam logic [11:0] DECL_E1_ITU  = 12'h800;
  // Loss-of-signal clear: window length, marks needed, zero-run limit
  localparam logic [7:0] WIN_T1   = 8'h80;
  localparam logic [7:0] MARKS_T1 = 8'h10;
  localparam logic [7:0] ZMAX_T1  = 8'h64;
  localparam logic [7:0] WIN_E1   = 8'h20;
  localparam logic [7:0] MARKS_E1 = 8'h04;
  localparam logic [7:0] ZMAX_E1  = 8'h10;
  localparam logic [5:0] CLEAR_MARGIN_DB = 6'h04;
  // Automatic report period
  localparam int CLK_PERIOD_NS    = 10;
  localparam int REPORT_PERIOD_MS = 1000;
  localparam int REPORT_CYCLES    = REPORT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// >>> logic/lnd_top.sv
// Chosen here: the register addresses and the APB interface to the registers.
module lnd_top
  import lnd_pkg::*;
#(
  parameter int REPORT_PERIOD_CYC = REPORT_CYCLES
) (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        rx_bit_en,
  input  logic        rx_pos,
  input  logic        rx_neg,
  input  logic        amp_below_declare,
  input  logic        amp_above_clear,
  input  logic [5:0]  rx_level_db,
  output logic        rx_data,
  output logic        rx_data_valid,
  output logic        bipolar_violation,
  output logic        code_violation,
  output logic        excessive_zeros,
  output logic        signal_loss_state,
  output logic        irq
);
  localparam int SECW = $clog2(REPORT_PERIOD_CYC + 1);

  logic [15:0]     ctrl_r;
  logic [3:0]      int_en_r;
  logic [3:0]      int_st_r;
  logic [15:0]     count_r;
  logic [15:0]     result_r;
  logic            xfer_prev_r;
  logic [SECW-1:0] sec_r;
  logic            last_pol_r;
  logic            have_pulse_r;
  logic            last_v_pol_r;
  logic            have_v_r;
  logic [7:0]      zrun_r;
  logic            b8_act_r;
  logic [2:0]      b8_age_r;
  logic            kill_next_r;
  logic [7:0]      dly_r;
  logic [11:0]     low_run_r;
  logic [7:0]      win_pos_r;
  logic [7:0]      marks_r;
  logic [7:0]      wzrun_r;
  logic [7:0]      wzmax_r;
  logic            loss_r;

  logic       e1, coding, long_haul, pulse, viol, ami, b8zs, hdb3;
  logic       b8_first, b8_second, hdb_sub, bpv_ev, cv_ev, zrun_ev, count_inc;
  logic       manual_copy, auto_tick, copy, wr_fire, mapped;
  logic [7:0] zrun_nxt, dly_nxt;
  logic [4:0] q;

  assign e1        = ctrl_r[CTRL_E1_MODE];
  assign coding    = ctrl_r[CTRL_CODING];
  assign long_haul = ctrl_r[CTRL_LONG_HAUL];
  assign q         = ctrl_r[CTRL_THRESH_LSB +: 5];
  assign ami       = ~coding;
  assign b8zs      = coding & ~e1;
  assign hdb3      = coding & e1;

  function automatic logic [7:0] zero_limit(input logic a, input logic b8, input logic fcc);
    logic [7:0] l;
    l = ZL_HDB3;
    if (a) begin
      l = fcc ? ZL_AMI_FCC : ZL_AMI_ANSI;
    end else if (b8) begin
      l = ZL_B8ZS;
    end
    return l;
  endfunction

  function automatic logic [11:0] declare_limit(input logic is_e1, input logic itu);
    logic [11:0] d;
    d = is_e1 ? (itu ? DECL_E1_ITU : DECL_E1_G775) : (itu ? DECL_T1_ITU : DECL_T1_ANSI);
    return d;
  endfunction

  // APB slave: no wait states, answer registered in setup phase
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_INT_EN) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_RESULT);
  assign wr_fire = psel & penable & pready & pwrite & ~pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        pslverr <= ~mapped;
        unique case (paddr)
          ADDR_CTRL:   prdata <= {16'h0000, ctrl_r};
          ADDR_INT_EN: prdata <= {28'h000_0000, int_en_r};
          ADDR_STATUS: prdata <= {23'h00_0000, loss_r, 4'h0, int_st_r};
          ADDR_RESULT: prdata <= {16'h0000, result_r};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= CTRL_RST;
      int_en_r <= INT_EN_RST;
    end else if (wr_fire) begin
      if (paddr == ADDR_CTRL) ctrl_r <= pwdata[CTRL_WIDTH-1:0];
      if (paddr == ADDR_INT_EN) int_en_r <= pwdata[3:0];
    end
  end

  // Line decoding
  assign pulse     = rx_pos | rx_neg;
  assign viol      = pulse & have_pulse_r & (rx_pos == last_pol_r);
  assign b8_first  = b8zs & viol & (zrun_r == 8'h03);
  assign b8_second = b8zs & viol & b8_act_r & (b8_age_r == 3'h2) & (zrun_r == 8'h01);
  assign hdb_sub   = hdb3 & viol & ((zrun_r == 8'h03) | (zrun_r == 8'h02));
  assign bpv_ev    = rx_bit_en & ami & viol;
  assign cv_ev     = rx_bit_en & ((b8zs & viol & ~b8_first & ~b8_second) |
                                  (hdb3 & viol & have_v_r & (rx_pos == last_v_pol_r)));
  assign zrun_nxt  = pulse ? 8'h00 : ((zrun_r == 8'hFF) ? zrun_r : zrun_r + 8'h01);
  assign zrun_ev   = rx_bit_en & ~pulse &
                     (zrun_nxt == zero_limit(ami, b8zs, ctrl_r[CTRL_ZERO_STD]) + 8'h01);

  always_comb begin
    dly_nxt = {dly_r[6:0], pulse & ~kill_next_r};
    if (b8_second) begin
      dly_nxt = dly_nxt & 8'hF0;
    end
    if (hdb_sub) begin
      dly_nxt[0] = 1'b0;
      if (zrun_r == 8'h02) dly_nxt[3] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pol_r   <= 1'b0;
      have_pulse_r <= 1'b0;
      last_v_pol_r <= 1'b0;
      have_v_r     <= 1'b0;
      zrun_r       <= 8'h00;
      b8_act_r     <= 1'b0;
      b8_age_r     <= 3'h0;
      kill_next_r  <= 1'b0;
      dly_r        <= 8'h00;
    end else if (rx_bit_en) begin
      zrun_r      <= zrun_nxt;
      dly_r       <= dly_nxt;
      kill_next_r <= b8_second;
      if (pulse) begin
        last_pol_r   <= rx_pos;
        have_pulse_r <= 1'b1;
      end
      if (viol) begin
        last_v_pol_r <= rx_pos;
        have_v_r     <= 1'b1;
      end
      if (b8_first) begin
        b8_act_r <= 1'b1;
        b8_age_r <= 3'h0;
      end else if (b8_act_r) begin
        b8_age_r <= b8_age_r + 3'h1;
        if (b8_second || b8_age_r == 3'h7) b8_act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data           <= 1'b0;
      rx_data_valid     <= 1'b0;
      bipolar_violation <= 1'b0;
      code_violation    <= 1'b0;
      excessive_zeros   <= 1'b0;
    end else begin
      rx_data_valid     <= rx_bit_en;
      bipolar_violation <= bpv_ev;
      code_violation    <= cv_ev;
      excessive_zeros   <= zrun_ev;
      if (rx_bit_en) rx_data <= dly_nxt[7] | (loss_r & ctrl_r[CTRL_ALL_ONES]);
    end
  end

  // Excessive-zero counter and reporting
  assign count_inc   = zrun_ev & (ctrl_r[CTRL_ERRSEL_LSB +: 2] == ERR_COUNT_SEL);
  assign manual_copy = ~ctrl_r[CTRL_REPORT_MODE] & ctrl_r[CTRL_TRANSFER] & ~xfer_prev_r;
  assign auto_tick   = ctrl_r[CTRL_REPORT_MODE] & (sec_r == SECW'(REPORT_PERIOD_CYC - 1));
  assign copy        = manual_copy | auto_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r       <= '0;
      xfer_prev_r <= 1'b0;
    end else begin
      xfer_prev_r <= ctrl_r[CTRL_TRANSFER];
      sec_r       <= (!ctrl_r[CTRL_REPORT_MODE] || auto_tick) ? '0 : sec_r + SECW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r  <= 16'h0000;
      result_r <= 16'h0000;
    end else if (copy) begin
      result_r <= count_r;
      count_r  <= {15'h0000, count_inc};
    end else if (count_inc) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Loss-of-signal detection
  logic        amp_low, amp_high, win_end, win_pass;
  logic [7:0]  marks_nxt, wzrun_nxt, wzmax_nxt;
  logic [11:0] low_run_nxt;

  assign amp_low   = long_haul ? (rx_level_db < {1'b0, q}) : amp_below_declare;
  assign amp_high  = long_haul ? (rx_level_db >= {1'b0, q} + CLEAR_MARGIN_DB) : amp_above_clear;
  assign low_run_nxt = amp_low ? ((low_run_r == 12'hFFF) ? low_run_r : low_run_r + 12'h001) : 12'h000;
  assign marks_nxt = marks_r + {7'h00, pulse};
  assign wzrun_nxt = pulse ? 8'h00 : ((wzrun_r == 8'hFF) ? wzrun_r : wzrun_r + 8'h01);
  assign wzmax_nxt = (wzrun_nxt > wzmax_r) ? wzrun_nxt : wzmax_r;
  assign win_end   = (win_pos_r == (e1 ? WIN_E1 : WIN_T1) - 8'h01);
  assign win_pass  = (marks_nxt >= (e1 ? MARKS_E1 : MARKS_T1)) &
                     (wzmax_nxt < (e1 ? ZMAX_E1 : ZMAX_T1)) & amp_high;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_run_r <= 12'h000;
      win_pos_r <= 8'h00;
      marks_r   <= 8'h00;
      wzrun_r   <= 8'h00;
      wzmax_r   <= 8'h00;
      loss_r    <= 1'b0;
    end else if (rx_bit_en) begin
      low_run_r <= low_run_nxt;
      wzrun_r   <= wzrun_nxt;
      if (win_end) begin
        win_pos_r <= 8'h00;
        marks_r   <= 8'h00;
        wzmax_r   <= 8'h00;
      end else begin
        win_pos_r <= win_pos_r + 8'h01;
        marks_r   <= marks_nxt;
        wzmax_r   <= wzmax_nxt;
      end
      if (!loss_r && low_run_nxt >= declare_limit(e1, ctrl_r[CTRL_LOSS_CRIT])) begin
        loss_r <= 1'b1;
      end else if (loss_r && win_end && win_pass) begin
        loss_r <= 1'b0;
      end
    end
  end

  // Sticky status, interrupt output
  logic       loss_prev_r;
  logic       loss_edge;
  logic [3:0] st_set, st_clr;

  assign loss_edge = ctrl_r[CTRL_EDGE_SEL] ? (loss_r != loss_prev_r) : (loss_r & ~loss_prev_r);
  assign st_set    = {loss_edge, count_inc & (count_r == 16'hFFFF) & ~copy, zrun_ev, bpv_ev | cv_ev};
  assign st_clr    = (wr_fire && paddr == ADDR_STATUS) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_prev_r       <= 1'b0;
      int_st_r          <= 4'h0;
      irq               <= 1'b0;
      signal_loss_state <= 1'b0;
    end else begin
      loss_prev_r       <= loss_r;
      signal_loss_state <= loss_r;
      int_st_r          <= (int_st_r & ~st_clr) | st_set;
      irq               <= |(int_st_r & int_en_r);
    end
  end

  // Checks
  property p_bpv_evt;
    @(posedge pclk) disable iff (!presetn) rx_bit_en & ami & viol |=> bipolar_violation;
  endproperty
  a_bpv_evt: assert property (p_bpv_evt) else $error("violation event missing");

  property p_cv_b8;
    @(posedge pclk) disable iff (!presetn) rx_bit_en & b8zs & viol & (zrun_r > 8'h03) |=> code_violation;
  endproperty
  a_cv_b8: assert property (p_cv_b8) else $error("B8ZS code violation missed");

  property p_no_cv_ami;
    @(posedge pclk) disable iff (!presetn) $past(ami) & $past(rx_bit_en) |-> !code_violation;
  endproperty
  a_no_cv_ami: assert property (p_no_cv_ami) else $error("code violation in AMI");

  property p_hdb_zrun;
    @(posedge pclk) disable iff (!presetn) rx_bit_en & hdb3 & ~pulse & (zrun_r == 8'h03) |=> excessive_zeros;
  endproperty
  a_hdb_zrun: assert property (p_hdb_zrun) else $error("HDB3 zero run missed");

  property p_b8_zrun;
    @(posedge pclk) disable iff (!presetn) rx_bit_en & b8zs & zrun_nxt == 8'h08 |=> excessive_zeros;
  endproperty
  a_b8_zrun: assert property (p_b8_zrun) else $error("B8ZS zero run missed");

  property p_copy;
    @(posedge pclk) disable iff (!presetn) copy |=> (result_r == $past(count_r)) && (count_r <= 16'h0001);
  endproperty
  a_copy: assert property (p_copy) else $error("counter copy wrong");

  property p_irq;
    @(posedge pclk) disable iff (!presetn) ##1 irq == $past(|(int_st_r & int_en_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");

  property p_all_ones;
    @(posedge pclk) disable iff (!presetn) rx_bit_en & loss_r & ctrl_r[CTRL_ALL_ONES] |=> rx_data;
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("all ones not inserted");

  property p_declare;
    @(posedge pclk) disable iff (!presetn)
      rx_bit_en & ~e1 & ~ctrl_r[CTRL_LOSS_CRIT] & amp_low & (low_run_r == 12'h0AE) |=> loss_r;
  endproperty
  a_declare: assert property (p_declare) else $error("loss not declared at 175");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn) int_st_r[ST_VIOL] & ~st_clr[ST_VIOL] |=> int_st_r[ST_VIOL];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status not sticky");

  c_cv:    cover property (@(posedge pclk) disable iff (!presetn) code_violation);
  c_copy:  cover property (@(posedge pclk) disable iff (!presetn) copy & count_inc);
  c_loss:  cover property (@(posedge pclk) disable iff (!presetn) loss_r ##1 !loss_r);
  c_ovf:   cover property (@(posedge pclk) disable iff (!presetn) st_set[ST_OVF]);
endmodule

// >>> sim/lnd_line_tx.sv
module lnd_line_tx (
  input  logic pclk,
  output logic rx_bit_en,
  output logic rx_pos,
  output logic rx_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] last;
  initial begin
    rx_bit_en = 1'b0;
    {rx_neg, rx_pos} = 2'b10;
    last = 2'b10;
  end
  // One bit every two cycles; lines show junk outside the strobe
  task automatic put(input logic [1:0] s);
    @(posedge pclk);
    rx_bit_en <= 1'b1;
    {rx_neg, rx_pos} <= s;
    if (s != 2'b00) last = s;
    @(posedge pclk);
    rx_bit_en <= 1'b0;
    {rx_neg, rx_pos} <= (s == 2'b00) ? 2'b10 : ~s;
  endtask
  task automatic mark();
    put(~last);
  endtask
  task automatic viol();
    put(last);
  endtask
  task automatic zeros(input int n);
    repeat (n) put(2'b00);
  endtask
endmodule

// >>> sim/lnd_top_tb.sv
module lnd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lnd_pkg::*;
  localparam int RPC = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_bit_en, rx_pos, rx_neg, amp_lo, amp_hi, ones_chk;
  logic        rx_data, rx_data_valid, bipolar_violation, code_violation;
  logic        excessive_zeros, signal_loss_state, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r;
  logic [15:0] ctrl;
  logic [5:0]  lvl;
  int          miscompares, n_compared, n_bpv, n_cv, n_exz, seed;
  int          run, eb, ee, e0, c0, b0, lim, w, m;
  int          dn[4] = '{175, 1544, 32, 2048};

  lnd_top #(.REPORT_PERIOD_CYC(RPC)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_bit_en, .rx_pos, .rx_neg, .amp_below_declare(amp_lo), .amp_above_clear(amp_hi),
    .rx_level_db(lvl), .rx_data, .rx_data_valid, .bipolar_violation, .code_violation,
    .excessive_zeros, .signal_loss_state, .irq
  );
  lnd_line_tx tx (.pclk, .rx_bit_en, .rx_pos, .rx_neg);

  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (bipolar_violation === 1'b1) n_bpv++;
    if (code_violation === 1'b1) n_cv++;
    if (excessive_zeros === 1'b1) n_exz++;
    if (ones_chk && rx_data_valid === 1'b1) chk("rx_data", 32'h1, {31'h0, rx_data});
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic lchk(input logic e);
    wt(3);
    chk("loss", {31'h0, e}, {31'h0, signal_loss_state});
  endtask
  task automatic ichk(input logic e);
    wt(3);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // Sends marks, violations and zeros while tracking expected events
  task automatic play(input string s);
    for (int k = 0; k < s.len(); k++) begin
      if (s[k] == "z") begin
        tx.zeros(1);
        run++;
      end else begin
        if (run > 15) ee++;
        run = 0;
        if (s[k] == "v") begin
          tx.viol();
          eb++;
        end else begin
          tx.mark();
        end
      end
    end
  endtask
  function automatic int zlim(input logic e1, input logic cod, input logic fcc);
    if (cod) return e1 ? 3 : 7;
    return fcc ? 80 : 15;
  endfunction
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    wt(60000);
    miscompares++;
    give_verdict();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    amp_lo = 1'b0;
    amp_hi = 1'b1;
    lvl = 6'h3F;
    ones_chk = 1'b0;
    seed = 37;
    run = 0;
    wt(3);
    presetn <= 1'b1;
    rd("ctrl", ADDR_CTRL, {16'h0000, CTRL_RST});
    rd("int_en", ADDR_INT_EN, {28'h000_0000, INT_EN_RST});
    rd("status", ADDR_STATUS, 32'h0000_0000);
    rd("result", ADDR_RESULT, 32'h0000_0000);
    rd("unmapped", 12'h010, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    // Zero-run limit of every coding and standard, reported by hand
    for (int i = 0; i < 8; i++) begin
      ctrl = 16'h0008 | 16'(i);
      lim = zlim(i[0], i[1], i[2]);
      wr(ADDR_CTRL, {16'h0000, ctrl});
      wr(ADDR_CTRL, {16'h0000, ctrl | 16'h0040});
      wr(ADDR_CTRL, {16'h0000, ctrl});
      e0 = n_exz;
      c0 = n_cv;
      tx.mark();
      tx.zeros(lim);
      tx.mark();
      tx.zeros(lim + 1);
      play("mmmmmmmmmm");
      wr(ADDR_CTRL, {16'h0000, ctrl | 16'h0040});
      chk("exz_events", e0 + 1, n_exz);
      chk("cv_events", c0, n_cv);
      rd("result", ADDR_RESULT, 32'h0000_0001);
    end
    // Substitutions accepted, broken ones flagged
    wr(ADDR_CTRL, 32'h0000_0003);
    c0 = n_cv;
    play("zzzvmzzzvmmzzzvmmmmmmmmmm");
    chk("cv_events", c0 + 1, n_cv);
    wr(ADDR_CTRL, 32'h0000_0002);
    c0 = n_cv;
    play("zzzvmzvmvmmmmmmmmmm");
    chk("cv_events", c0 + 1, n_cv);
    // Random AMI stream with zero runs near the limit
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_STATUS, 32'h0000_000F);
    wr(ADDR_INT_EN, 32'h0000_0001);
    eb = 0;
    ee = 0;
    b0 = n_bpv;
    e0 = n_exz;
    repeat (300) begin
      r = $random(seed);
      if (r[3:0] == 4'h0) repeat (14 + r[5:4]) play("z");
      else play(r[5:4] == 2'h3 ? "v" : (r[6] ? "m" : "z"));
    end
    play("mmm");
    chk("bpv_events", b0 + eb, n_bpv);
    chk("exz_events", e0 + ee, n_exz);
    wr(ADDR_CTRL, 32'h0000_0040);
    rd("result", ADDR_RESULT, 32'h0000_0000);
    ichk(eb > 0);
    wr(ADDR_STATUS, 32'h0000_0001);
    ichk(1'b0);
    wr(ADDR_INT_EN, 32'h0000_0002);
    ichk(ee > 0);
    // Automatic report period
    wr(ADDR_STATUS, 32'h0000_000F);
    wr(ADDR_CTRL, 32'h0000_0028);
    play("mzzzzzzzzzzzzzzzzmzzzzzzzzzzzzzzzzm");
    wt(RPC + 10);
    rd("result", ADDR_RESULT, 32'h0000_0002);
    wt(RPC + 10);
    rd("result", ADDR_RESULT, 32'h0000_0000);
    // Loss of signal under each mode and criterion
    wr(ADDR_INT_EN, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      w = i[1] ? 32 : 128;
      m = i[1] ? 4 : 16;
      r = $random(seed);
      lvl <= r[5:0];
      wr(ADDR_STATUS, 32'h0000_000F);
      wr(ADDR_CTRL, {16'h0000, 5'h00, i[0], 1'b1, 1'b0, i[0], 6'h00, i[1]});
      amp_lo <= 1'b1;
      amp_hi <= 1'b0;
      tx.zeros(dn[i] - 1);
      lchk(1'b0);
      tx.zeros(1);
      lchk(1'b1);
      ones_chk = 1'b1;
      tx.zeros(12);
      ones_chk = 1'b0;
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_0108, q & 32'h0000_0108);
      ichk(1'b1);
      wr(ADDR_STATUS, 32'h0000_0008);
      amp_lo <= 1'b0;
      amp_hi <= 1'b1;
      repeat (m - 1) tx.mark();
      lchk(1'b1);
      repeat (2 * w) tx.mark();
      lchk(1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("loss_int", {28'h000_0000, i[0], 3'h0}, q & 32'h0000_0008);
    end
    // Long haul threshold and clear margin
    wr(ADDR_CTRL, 32'h0000_5101);
    lvl <= 6'h09;
    tx.zeros(32);
    lchk(1'b1);
    lvl <= 6'h0D;
    repeat (64) tx.mark();
    lchk(1'b1);
    lvl <= 6'h0E;
    repeat (64) tx.mark();
    lchk(1'b0);
    give_verdict();
  end
endmodule
